//--- hdl/rxfsd_rx_top.sv
// rxfsd_rx_top: receive byte buffer, sync recognition and rate setting
// assumes the host clocks 16-bit commands on SPI_SCK in mode 0, msb first
`timescale 1ns/1ps
module rxfsd_rx_top
  import rxfsd_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_BIT_CYCLES
)(
  // core clock and reset
  input  wire logic  CLOCK,
  input  wire logic  RST_N,
  input  wire logic  CLK_EN,
  // host serial link
  input  wire logic  SPI_SCK,
  input  wire logic  SPI_CS_N,
  input  wire logic  SPI_MOSI,
  output logic       SPI_MISO,
  // demodulated data and buffer enable from general config
  input  wire logic  RX_DATA,
  input  wire logic  BUF_ENABLE,
  // status toward the host and the supply supervisor
  output logic       FILL_IRQ,
  output logic       SYNC_FOUND,
  output logic       BUF_OVERRUN,
  output logic       RESET_SENSITIVE
);

  rxfsd_link_if lnk ();

  // serial shifter on the host's clock
  rxfsd_link u_link (
    .sck   (SPI_SCK),
    .rst_n (RST_N),
    .cs_n  (SPI_CS_N),
    .mosi  (SPI_MOSI),
    .miso  (SPI_MISO),
    .lnk   (lnk.link)
  );

  // synchronisers for toggle, select and data pin
  logic tgl_s1, tgl_s2, tgl_s3;
  logic cs_s1, cs_s2;
  logic rx_s1, rx_s2;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      rx_s1  <= 1'b0;
      rx_s2  <= 1'b0;
    end else if (CLK_EN) begin
      tgl_s1 <= lnk.word_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      cs_s1  <= SPI_CS_N;
      cs_s2  <= cs_s1;
      rx_s1  <= RX_DATA;
      rx_s2  <= rx_s1;
    end
  end

  // command decode; word is stable long before the toggle lands
  wire cmd_stb  = CLK_EN & (tgl_s2 ^ tgl_s3);
  wire is_read  = cmd_stb & rxfsd_cmd_is(lnk.word, CMD_READ);
  wire is_fill  = cmd_stb & rxfsd_cmd_is(lnk.word, CMD_FILL);
  wire is_sync  = cmd_stb & rxfsd_cmd_is(lnk.word, CMD_SYNC);
  wire is_rate  = cmd_stb & rxfsd_cmd_is(lnk.word, CMD_RATE);

  // configuration bytes
  logic [7:0] fill_cfg;
  logic [7:0] sync_byte_value;
  logic [7:0] rate_cfg;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fill_cfg        <= RST_FILL[7:0];
      sync_byte_value <= RST_SYNC[7:0];
      rate_cfg        <= RST_RATE[7:0];
    end else begin
      if (is_fill) fill_cfg        <= lnk.word[7:0];
      if (is_sync) sync_byte_value <= lnk.word[7:0];
      if (is_rate) rate_cfg        <= lnk.word[7:0];
    end
  end

  // field views
  wire [3:0] fill_count      = fill_cfg[FILL_CNT_HI:FILL_CNT_LO];
  wire       sync_length_sel = fill_cfg[SYNC_LEN_BIT];
  wire       fill_start_cond = fill_cfg[START_BIT];
  wire       fill_control    = fill_cfg[CTRL_BIT];
  wire       reset_mode_sel  = fill_cfg[RMODE_BIT];
  wire       rate_prescale_en = rate_cfg[PRE_BIT];
  wire [6:0] rate_parameter  = rate_cfg[PARAM_HI:0];
  wire [7:0] sync_low_byte   = sync_byte_value;
  wire [7:0] sync_high_byte  = SYNC_HIGH_BYTE;

  // expected bit-rate strobe
  logic bit_tick;

  rxfsd_rate_gen #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_rate (
    .clk         (CLOCK),
    .rst_n       (RST_N),
    .clk_en      (CLK_EN),
    .prescale_en (rate_prescale_en),
    .param       (rate_parameter),
    .tick        (bit_tick)
  );

  // history of recovered bits and exact pattern compare
  logic [15:0] hist;
  wire  [15:0] next_hist  = {hist[14:0], rx_s2};
  wire         byte_match = next_hist[7:0] == sync_low_byte;
  wire         word_match = next_hist == {sync_high_byte, sync_low_byte};
  // byte-long when the length bit is set, else the 2d-prefixed word
  wire         sync_match = sync_length_sel ? byte_match
                                            : word_match;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) hist <= '0;
    else if (CLK_EN && bit_tick) hist <= next_hist;
  end

  // fill state machine; arming needs both fill control and the buffer enable
  rxfsd_state_type state, next_state;
  wire armed = fill_control & BUF_ENABLE;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (armed) next_state = fill_start_cond ? ST_FILL : ST_HUNT;
      end
      ST_HUNT: begin
        if (!armed) next_state = ST_OFF;
        else if (fill_start_cond) next_state = ST_FILL;
        else if (bit_tick && sync_match) next_state = ST_FILL;
      end
      ST_FILL: begin
        // only a clear of fill control or of the buffer enable restarts sync hunting
        if (!armed) next_state = ST_OFF;
      end
      default: next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) state <= ST_OFF;
    else if (CLK_EN) state <= next_state;
  end

  // byte buffer: partial byte assembly, then whole bytes in memory
  logic [7:0]        mem [BUF_DEPTH];
  logic [BUF_AW-1:0] wr_ptr, rd_ptr;
  logic [BUF_AW:0]   count;
  logic [7:0]        asm_byte;
  logic [2:0]        part_cnt;
  logic              out_valid;

  // the pattern bit itself is not stored; filling starts after it
  wire push_bit = bit_tick & (state == ST_FILL);
  wire byte_done = push_bit & (part_cnt == BYTE_LAST);
  wire full      = count == BUF_FULL;
  wire byte_wr   = CLK_EN & byte_done & ~full;
  wire byte_lost = CLK_EN & byte_done & full;
  wire pop       = is_read & out_valid & (count != '0);
  wire [7:0] bits_in = {count, 3'h0} + {5'h00, part_cnt};
  wire [7:0] fill_bits = {4'h0, fill_count};
  // zero count still waits for one bit, so the line never idles high
  wire irq_level = (bits_in != '0) && (bits_in >= fill_bits);

  // memory write; no reset on the array, count guards reads
  always_ff @(posedge CLOCK) begin
    if (byte_wr) mem[wr_ptr] <= {asm_byte[6:0], rx_s2};
  end

  // assembly of bits msb first; dropped when filling stops
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      asm_byte <= '0;
      part_cnt <= '0;
    end else if (CLK_EN) begin
      if (state == ST_OFF) part_cnt <= '0;
      else if (push_bit) begin
        asm_byte <= {asm_byte[6:0], rx_s2};
        part_cnt <= part_cnt + 3'h1;
      end
    end
  end

  // pointers and count; a full buffer never stalls the radio side
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (byte_wr) wr_ptr <= wr_ptr + 4'h1;
      if (pop)     rd_ptr <= rd_ptr + 4'h1;
      if (byte_wr && !pop) count <= count + 5'h01;
      else if (pop && !byte_wr) count <= count - 5'h01;
    end
  end

  // oldest byte for the link, refreshed only while no frame runs
  // out_valid remembers whether the frame in flight carried a real byte,
  // so a byte that lands mid-frame is never popped unseen
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lnk.out_byte <= RST_READ[7:0];
      out_valid    <= 1'b0;
    end else if (CLK_EN && cs_s2) begin
      lnk.out_byte <= (count != '0) ? mem[rd_ptr] : RST_READ[7:0];
      out_valid    <= count != '0;
    end
  end

  // status outputs; overrun set wins over the clear by a read
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      FILL_IRQ        <= 1'b0;
      SYNC_FOUND      <= 1'b0;
      BUF_OVERRUN     <= 1'b0;
      RESET_SENSITIVE <= 1'b0;
    end else if (CLK_EN) begin
      FILL_IRQ        <= irq_level;
      SYNC_FOUND      <= state == ST_FILL;
      if (byte_lost) BUF_OVERRUN <= 1'b1;
      else if (is_read) BUF_OVERRUN <= 1'b0;
      // low bit selects the sensitive supply reset
      RESET_SENSITIVE <= ~reset_mode_sel;
    end
  end

  // checks on the core clock
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_read_drains_byte : assert property (
    pop && !byte_wr |=> count == $past(count) - 5'h01)
    else $error("read did not remove one byte");

  a_fill_cfg_load : assert property (
    is_fill |=> fill_cfg == $past(lnk.word[7:0]))
    else $error("fill config not loaded from command");

  a_irq_on_level : assert property (
    CLK_EN && bits_in >= fill_bits && bits_in != '0 |=> FILL_IRQ)
    else $error("interrupt missing at fill level");

  a_word_sync_hit : assert property (
    CLK_EN && state == ST_HUNT && armed && bit_tick && !sync_length_sel
    && next_hist == {SYNC_HIGH_BYTE, sync_byte_value}
    |=> state == ST_FILL)
    else $error("word sync pattern not recognised");

  a_hunt_stores_none : assert property (
    state == ST_HUNT |-> !byte_wr ##1 $stable(count) || $past(pop))
    else $error("bytes stored before sync");

  a_ctrl_clear_stops : assert property (
    CLK_EN && !fill_control |=> state == ST_OFF ##1 !byte_wr)
    else $error("filling went on with control cleared");

  a_reset_mode_out : assert property (
    CLK_EN |=> RESET_SENSITIVE == !$past(reset_mode_sel))
    else $error("reset sensitivity does not follow mode bit");

  a_full_discards : assert property (
    byte_lost && !pop |=> full && BUF_OVERRUN)
    else $error("overflow byte not discarded or not flagged");

  a_sync_byte_load : assert property (
    is_sync |=> sync_byte_value == $past(lnk.word[7:0]))
    else $error("sync byte not stored");

  a_rate_load : assert property (
    is_rate |=> rate_cfg == $past(lnk.word[7:0]))
    else $error("rate setting not stored");

  a_irq_drops : assert property (
    CLK_EN && bits_in < fill_bits |=> !FILL_IRQ)
    else $error("interrupt held below fill level");

  // buffer bookkeeping, state and configuration checks
  a_overrun_sticky : assert property (
    BUF_OVERRUN && !is_read |=> BUF_OVERRUN)
    else $error("overrun flag cleared without a read");

  a_empty_read_safe : assert property (
    is_read && count == '0 |=> count == '0 || $past(byte_wr))
    else $error("read of empty buffer changed the count");

  a_off_no_store : assert property (
    CLK_EN && !BUF_ENABLE |=> state == ST_OFF)
    else $error("filling while buffer disabled");

  a_byte_sync_hit : assert property (
    CLK_EN && state == ST_HUNT && armed && bit_tick && sync_length_sel
    && next_hist[7:0] == sync_byte_value |=> state == ST_FILL)
    else $error("byte sync pattern not recognised");

  a_start_cond_fills : assert property (
    CLK_EN && armed && fill_start_cond |=> state == ST_FILL)
    else $error("start condition did not fill at once");

  a_count_bounded : assert property (
    count <= BUF_FULL)
    else $error("byte count beyond buffer depth");

  a_pop_needs_byte : assert property (
    pop |-> count != '0)
    else $error("read popped an empty buffer");

  a_other_cmds_ignored : assert property (
    cmd_stb && !is_fill && !is_sync && !is_rate
    |=> $stable(fill_cfg) && $stable(sync_byte_value) && $stable(rate_cfg))
    else $error("configuration changed by a foreign command");

  c_read_with_data : cover property (pop);
  c_word_sync      : cover property (
    state == ST_HUNT && !sync_length_sel ##1 state == ST_FILL);
  c_sync_then_fill : cover property (state == ST_HUNT ##1 state == ST_FILL);
  c_overflow       : cover property (byte_lost);
  c_irq_rise       : cover property (!FILL_IRQ ##1 FILL_IRQ);

endmodule

//--- hdl/rxfsd_pkg.sv
// rxfsd_pkg: constants, field layout and types of the receive data path
// assumes a 100 MHz core clock and 16-bit serial commands from the host
package rxfsd_pkg;

  // core clock and the bit-rate base of 10000/29 kbps
  localparam int CLK_HZ           = 100_000_000;
  localparam int RATE_NUM_KBPS    = 10_000;
  localparam int RATE_DEN         = 29;
  // cycles of one base bit period, rounded down
  localparam int BASE_BIT_CYCLES  = (CLK_HZ / 1000) * RATE_DEN / RATE_NUM_KBPS;
  localparam int RATE_BASE_W      = 18;
  localparam int RATE_MULT_W      = 10;
  localparam int PRESCALE_SHIFT   = 3;   // prescaler divides by eight

  // serial frame layout
  localparam int          FRAME_BITS = 16;
  localparam int          CNT_W      = 5;
  localparam logic [4:0]  FRAME_LAST = 5'h0f;
  localparam logic [4:0]  FRAME_END  = 5'h10;
  localparam logic [4:0]  DATA_FIRST = 5'h08;

  // command codes in the upper byte
  localparam logic [7:0] CMD_READ = 8'hb0;
  localparam logic [7:0] CMD_FILL = 8'hca;
  localparam logic [7:0] CMD_SYNC = 8'hce;
  localparam logic [7:0] CMD_RATE = 8'hc6;

  // reset values of the command words
  localparam logic [15:0] RST_READ = 16'hb000;
  localparam logic [15:0] RST_FILL = 16'hca80;
  localparam logic [15:0] RST_SYNC = 16'hced4;
  localparam logic [15:0] RST_RATE = 16'hc623;

  // field positions inside the low byte
  localparam int FILL_CNT_HI  = 7;
  localparam int FILL_CNT_LO  = 4;
  localparam int SYNC_LEN_BIT = 3;
  localparam int START_BIT    = 2;
  localparam int CTRL_BIT     = 1;
  localparam int RMODE_BIT    = 0;
  localparam int PRE_BIT      = 7;
  localparam int PARAM_HI     = 6;

  // fixed upper half of the word-long sync pattern
  localparam logic [7:0] SYNC_HIGH_BYTE = 8'h2d;

  // byte buffer geometry
  localparam int          BUF_DEPTH = 16;
  localparam int          BUF_AW    = 4;
  localparam logic [4:0]  BUF_FULL  = 5'h10;
  localparam logic [2:0]  BYTE_LAST = 3'h7;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_HUNT = 3'b010,
    ST_FILL = 3'b100
  } rxfsd_state_type;

  // true when a command word carries the given code
  function automatic logic rxfsd_cmd_is(input logic [15:0] w,
                                        input logic [7:0]  code);
    return w[15:8] == code;
  endfunction

endpackage

//--- hdl/rxfsd_link_if.sv
// rxfsd_link_if: words passed between the serial link and the core
// assumes word and byte stay stable while the far side samples them
`timescale 1ns/1ps
interface rxfsd_link_if;
  logic [15:0] word;
  logic        word_tgl;
  logic [7:0]  out_byte;
  modport link (output word, word_tgl, input out_byte);
  modport core (input word, word_tgl, output out_byte);
endinterface

//--- hdl/rxfsd_link.sv
// rxfsd_link: serial command shifter on the host's own clock
// assumes the clock stands still outside frames; select frames each word
`timescale 1ns/1ps
module rxfsd_link
  import rxfsd_pkg::*;
(
  // serial pins
  input  wire logic   sck,
  input  wire logic   rst_n,
  input  wire logic   cs_n,
  input  wire logic   mosi,
  output logic        miso,
  // core side
  rxfsd_link_if.link  lnk
);

  logic [CNT_W-1:0] bit_cnt;
  logic [15:0]      shreg;
  // the frame's own select ends it, no edge after the last is needed
  wire              frame_rst_n = rst_n & ~cs_n;
  wire              in_data     = bit_cnt >= DATA_FIRST;

  // shift in, count up to sixteen and hold there
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= '0;
      shreg   <= '0;
    end else begin
      shreg <= {shreg[14:0], mosi};
      if (bit_cnt != FRAME_END) bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // whole word captured and announced by toggle on the 16th edge
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      lnk.word     <= RST_READ;
      lnk.word_tgl <= 1'b0;
    end else if (bit_cnt == FRAME_LAST) begin
      lnk.word     <= {shreg[14:0], mosi};
      lnk.word_tgl <= ~lnk.word_tgl;
    end
  end

  // oldest byte out on falling edges of the low half, msb first
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) miso <= 1'b0;
    else if (in_data && bit_cnt != FRAME_END)
      miso <= lnk.out_byte[~bit_cnt[2:0]];
    else miso <= 1'b0;
  end

endmodule

//--- hdl/rxfsd_rate_gen.sv
// rxfsd_rate_gen: expected bit-rate strobe from parameter and prescaler
// assumes base_cycles equals one base bit period in core clocks
`timescale 1ns/1ps
module rxfsd_rate_gen
  import rxfsd_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_BIT_CYCLES
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // rate setting
  input  wire logic       prescale_en,
  input  wire logic [6:0] param,
  // strobe
  output logic            tick
);

  logic [RATE_BASE_W-1:0] base_cnt;
  logic [RATE_MULT_W-1:0] mult_cnt;
  wire  [RATE_BASE_W-1:0] base_top = RATE_BASE_W'(BASE_CYCLES - 1);
  // (param+1) base periods, eight times that with prescaler
  wire  [RATE_MULT_W-1:0] mult_top = prescale_en ?
          {param, 3'h7} : {3'h0, param};

  // >= lets a new setting take effect mid-period without a wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt <= '0;
      mult_cnt <= '0;
      tick     <= 1'b0;
    end else if (clk_en) begin
      tick <= 1'b0;
      if (base_cnt >= base_top) begin
        base_cnt <= '0;
        if (mult_cnt >= mult_top) begin
          mult_cnt <= '0;
          tick     <= 1'b1;
        end else mult_cnt <= mult_cnt + 10'h001;
      end else base_cnt <= base_cnt + 18'h0_0001;
    end
  end

  a_tick_isolated : assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && tick && BASE_CYCLES > 1 |=> !tick)
    else $error("bit strobe lasted more than one cycle");

endmodule

//--- test/rxfsd_host.sv
// rxfsd_host: host-side serial master that issues 16-bit commands
// assumes mode 0, msb first; its clock runs only inside frames
`timescale 1ns/1ps
module rxfsd_host (
  // serial pins
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // one whole frame: code in the upper byte, data or reply below
  task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd);
    integer i;
    rd = 8'h00;
    cs_n <= 1'b0;
    #40; // select setup, more than three core cycles
    for (i = 15; i >= 0; i--) begin
      mosi <= cmd[i];
      #6;
      sck <= 1'b1;
      if (i < 8) rd = {rd[6:0], miso}; // reply bits ride rises 9..16
      #6;
      sck <= 1'b0;
    end
    #6;
    cs_n <= 1'b1;
    mosi <= ~mosi; // inverted line, so no stale level lingers
    #100; // gap covers deselect sync and core decode
  endtask
endmodule

//--- test/rxfsd_rx_top_tb.sv
// rxfsd_rx_top_tb: self-checking bench for the receive data path
// assumes the host model above and a shortened base bit period
`timescale 1ns/1ps
module rxfsd_rx_top_tb;
  import rxfsd_pkg::*;
  localparam int BASE = 4;
  logic       clock;
  logic       rst_n;
  logic       rx_data;
  logic       buf_enable;
  logic       clk_en;
  logic       sck, cs_n, mosi, miso;
  logic       fill_irq, sync_found, buf_overrun, reset_sensitive;
  integer     err_count = 0;
  integer     comparisons = 0;
  integer     seed = 89;
  integer     cycles = 0;
  integer     hold = 0;
  integer     per = BASE * 36; // bit period at the reset rate
  integer     i;
  logic       idle = 1'b1;
  logic       bit_q[$];
  logic [7:0] exp_q[$];
  logic [7:0] rd, b, sync_b;
  logic [6:0] p;

  rxfsd_rx_top #(.BASE_CYCLES(BASE)) u_rxfsd_rx_top (
    .CLOCK(clock), .RST_N(rst_n), .CLK_EN(clk_en),
    .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso),
    .RX_DATA(rx_data), .BUF_ENABLE(buf_enable),
    .FILL_IRQ(fill_irq), .SYNC_FOUND(sync_found),
    .BUF_OVERRUN(buf_overrun), .RESET_SENSITIVE(reset_sensitive));
  rxfsd_host u_rxfsd_host (.sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // bit source: each bit held exactly one strobe period, so phase
  // is irrelevant and every bit is sampled once
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      wrap_up();
    end else if (hold <= 1) begin
      hold <= per;
      rx_data <= (bit_q.size() > 0) ? bit_q.pop_front() : idle;
    end else hold <= hold - 1;
  end

  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] code, input logic [7:0] val);
    u_rxfsd_host.xfer({code, val}, rd);
  endtask

  // read one byte; the model queue gives the oldest, or zero if empty
  task automatic rd_chk;
    logic [7:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00;
    u_rxfsd_host.xfer({CMD_READ, 8'h00}, rd);
    check(rd, e);
  endtask

  // empty the buffer, every byte left over must equal v
  task automatic drain(input logic [7:0] v);
    integer k;
    k = 0;
    rd = 8'h01;
    while (rd !== 8'h00 && k < 17) begin
      u_rxfsd_host.xfer({CMD_READ, 8'h00}, rd);
      if (rd !== 8'h00) check(rd, v);
      k++;
    end
    check(rd, 8'h00);
  endtask

  task automatic send(input logic [7:0] v);
    integer k;
    for (k = 7; k >= 0; k--) bit_q.push_back(v[k]);
  endtask

  // wait for the source to run dry plus sync and store latency
  task automatic wait_stream;
    while (bit_q.size() != 0) @(posedge clock);
    repeat (3 * per + 8) @(posedge clock);
  endtask

  initial begin
    rst_n = 1'b0;
    buf_enable = 1'b0;
    clk_en = 1'b1;
    rx_data = 1'b1;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check({7'h0, reset_sensitive}, 8'h01);
    check({7'h0, sync_found}, 8'h00);
    check({7'h0, fill_irq}, 8'h00);
    rd_chk();
    // continuous fill, first with the buffer disabled
    cmd(CMD_FILL, 8'h16);
    repeat (12 * per) @(posedge clock);
    rd_chk();
    @(posedge clock);
    buf_enable <= 1'b1;
    // core frozen: the enable must not move the fill state yet
    clk_en <= 1'b0;
    repeat (8) @(posedge clock);
    check({7'h0, sync_found}, 8'h00);
    clk_en <= 1'b1;
    repeat (12 * per) @(posedge clock);
    cmd(CMD_FILL, 8'h14);
    check({7'h0, reset_sensitive}, 8'h01);
    drain(8'hff);
    // byte sync on the reset sync byte and reset rate
    cmd(CMD_FILL, 8'h8b);
    check({7'h0, reset_sensitive}, 8'h00);
    check({7'h0, sync_found}, 8'h00);
    send(8'hd4);
    for (i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      send(b);
      exp_q.push_back(b);
    end
    wait_stream();
    check({7'h0, sync_found}, 8'h01);
    check({7'h0, fill_irq}, 8'h01);
    cmd(CMD_FILL, 8'h89);
    rd_chk();
    rd_chk();
    drain(8'hff);
    // random sync byte and rate, overfilled by one byte
    sync_b = {1'b0, 6'($random(seed)), 1'b1}; // no match in idle ones
    p = 7'($random(seed) & 3);
    cmd(CMD_RATE, {1'b0, p});
    per = BASE * (p + 1);
    cmd(CMD_SYNC, sync_b);
    cmd(CMD_FILL, 8'hfb);
    send(sync_b);
    for (i = 0; i < 17; i++) begin
      b = 8'($random(seed));
      send(b);
      if (i < 16) exp_q.push_back(b);
    end
    wait_stream();
    check({7'h0, buf_overrun}, 8'h01);
    check({7'h0, fill_irq}, 8'h01);
    cmd(CMD_FILL, 8'hf9);
    for (i = 0; i < 16; i++) begin
      rd_chk();
      check({7'h0, buf_overrun}, 8'h00);
      check({7'h0, fill_irq}, {7'h0, exp_q.size() * 8 >= 15});
    end
    rd_chk();
    // word sync with prescaler; a lone sync byte must not match
    p = 7'($random(seed) & 1);
    cmd(CMD_RATE, {1'b1, p});
    per = BASE * (p + 1) * 8;
    cmd(CMD_FILL, 8'h83);
    send(sync_b);
    send(8'h00);
    send(8'h00);
    send(SYNC_HIGH_BYTE);
    send(sync_b);
    for (i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      send(b);
      exp_q.push_back(b);
    end
    wait_stream();
    cmd(CMD_FILL, 8'h81);
    for (i = 0; i < 3; i++) rd_chk();
    drain(8'hff);
    wrap_up();
  end
endmodule
